/* File: src/sac_clk_div.sv */
`timescale 1ns/1ps

// Machine clock tick from the core clock, and conversion clock tick from the machine tick.
module sac_clk_div (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire sac_pkg::sac_clk_cfg_t cfg_in,
    output logic mclk_tick_out,
    output logic aclk_tick_out
);

    typedef struct packed {
        logic [9:0] mcnt;
        logic [3:0] acnt;
        logic mtick;
        logic atick;
    } sac_div_state_t;

    sac_div_state_t st_r;
    sac_div_state_t st_nxt;
    logic [9:0] mlast;

    always_comb begin
        case (cfg_in.div_sel)
            sac_pkg::DIV_SEL_4: mlast = sac_pkg::MDIV_LAST_4;
            sac_pkg::DIV_SEL_64: mlast = sac_pkg::MDIV_LAST_64;
            default: mlast = sac_pkg::MDIV_LAST_1024;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.mtick = 1'b0;
        st_nxt.atick = 1'b0;
        if (st_r.mcnt >= mlast) begin
            st_nxt.mcnt = 10'h000;
            st_nxt.mtick = 1'b1;
        end else begin
            st_nxt.mcnt = st_r.mcnt + 10'h001;
        end
        // A restart realigns the prescale count only; the machine clock count keeps running, so the first period can be short.
        if (cfg_in.restart) begin
            st_nxt.acnt = 4'h0;
        end else if (st_r.mtick) begin
            if (st_r.acnt >= cfg_in.prescale) begin
                st_nxt.acnt = 4'h0;
                st_nxt.atick = 1'b1;
            end else begin
                st_nxt.acnt = st_r.acnt + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mclk_tick_out = st_r.mtick;
    assign aclk_tick_out = st_r.atick;

endmodule // sac_clk_div

/* File: src/sac_core.sv */
// Contract
// - Approximation tests result bits 9 down to 0, keep when DAC below input.
// - A conversion takes exactly 16 conversion clocks from start to completion flag.
// - Conversion clock period is machine clock period times prescale plus one.
// - Machine clock is core clock divided by 4, 64 or 1024 per divider.
// - Window comparator checks both 8-bit limits against the result upper byte.
// - Match flag is outside select XOR upper-less XOR lower-less, set at end.
// - Limits are symmetric; upper below lower gets no special handling.
// - Interrupt on every completion, or only with match when qualifier set.
// - Software start bit or enabled external falling edge starts, setting busy.
// - A running conversion stops only when converter power is removed.
// - Five clocks sample, ten approximate, completion flag on the final clock.
// - Continuous mode restarts on the next machine cycle, busy stays set.
// - Leaving continuous mode finishes the current conversion and then halts.
// - Converter leaves reset powered down; software waits warm-up after power on.
// - Start/busy stays set during conversion, ignores writes of 0, clears at end.
// - Clearing power aborts the conversion and forces start/busy to 0.
// - Three-bit channel select picks input n at the next conversion start.
// - Format bit 1 puts result bits 9:8 in low bits of upper byte.
`timescale 1ns/1ps

module sac_core (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire sac_pkg::sac_bus_req_t bus_req_in,
    output logic [7:0] bus_rdata_out,
    input wire logic ext_start_n_in,
    input wire logic comp_dac_below_in,
    output logic [9:0] dac_code_out,
    output logic [2:0] channel_out,
    output logic sample_out,
    output logic power_on_out,
    output logic converter_irq_out
);

    typedef struct packed {
        sac_pkg::sac_phase_t phase;
        logic [3:0] seq_cnt;
        logic [9:0] approximation_register;
        logic [9:0] result;
        logic window_match_flag;
        logic eoc_flag;
        logic start_busy_bit;
        logic continuous_mode_select;
        logic external_start_enable;
        logic window_qualify_enable;
        logic converter_power_on;
        logic window_outside_select;
        logic result_format_select;
        logic [2:0] channel_select;
        logic [2:0] channel_active;
        logic [3:0] clock_prescale_select;
        logic [1:0] machine_clock_divider;
        logic [7:0] window_upper_limit;
        logic [7:0] window_lower_limit;
        logic pin_sync1;
        logic pin_sync2;
        logic pin_prev;
        logic [7:0] rdata;
        logic irq;
        logic sample;
        logic restart;
    } sac_state_t;

    sac_state_t st_r;
    sac_state_t st_nxt;
    sac_pkg::sac_clk_cfg_t clk_cfg;
    logic mclk_tick;
    logic aclk_tick;

    assign clk_cfg.div_sel = st_r.machine_clock_divider;
    assign clk_cfg.prescale = st_r.clock_prescale_select;
    assign clk_cfg.restart = st_r.restart;

    sac_clk_div u_clk_div (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .cfg_in(clk_cfg),
        .mclk_tick_out(mclk_tick),
        .aclk_tick_out(aclk_tick)
    );

    logic [7:0] ctrl_one_rd;
    logic [7:0] ctrl_two_rd;
    logic [7:0] msb_rd;
    logic [3:0] bit_idx;
    logic [7:0] upper_byte;
    logic wr_ctrl_one;
    logic sw_start;
    logic pin_fall;
    logic power_nxt;

    always_comb begin
        ctrl_one_rd = {st_r.start_busy_bit, st_r.eoc_flag, st_r.continuous_mode_select,
                       st_r.external_start_enable, st_r.window_qualify_enable,
                       st_r.window_match_flag, st_r.converter_power_on,
                       st_r.window_outside_select};
        ctrl_two_rd = {st_r.result_format_select, st_r.channel_select,
                       st_r.clock_prescale_select};
        if (st_r.result_format_select) begin
            msb_rd = {6'h00, st_r.result[9:8]};
        end else begin
            msb_rd = st_r.result[9:2];
        end
    end

    always_comb begin
        st_nxt = st_r;
        bit_idx = sac_pkg::SEQ_DECIDE_LAST - st_r.seq_cnt;
        upper_byte = st_r.approximation_register[9:2];
        wr_ctrl_one = bus_req_in.wr && (bus_req_in.addr == sac_pkg::ADDR_CTRL_ONE);
        power_nxt = wr_ctrl_one ? bus_req_in.wdata[sac_pkg::BIT_POWER]
                                : st_r.converter_power_on;
        st_nxt.restart = 1'b0;

        // Start pin synchroniser and falling edge detector.
        st_nxt.pin_sync1 = ext_start_n_in;
        st_nxt.pin_sync2 = st_r.pin_sync1;
        st_nxt.pin_prev = st_r.pin_sync2;
        pin_fall = st_r.pin_prev && !st_r.pin_sync2;

        // Register writes.
        if (wr_ctrl_one) begin
            st_nxt.eoc_flag = bus_req_in.wdata[sac_pkg::BIT_EOC];
            st_nxt.continuous_mode_select = bus_req_in.wdata[sac_pkg::BIT_CONT];
            st_nxt.external_start_enable = bus_req_in.wdata[sac_pkg::BIT_EXT_START];
            st_nxt.window_qualify_enable = bus_req_in.wdata[sac_pkg::BIT_QUALIFY];
            st_nxt.converter_power_on = bus_req_in.wdata[sac_pkg::BIT_POWER];
            st_nxt.window_outside_select = bus_req_in.wdata[sac_pkg::BIT_OUTSIDE];
        end
        if (bus_req_in.wr) begin
            case (bus_req_in.addr)
                sac_pkg::ADDR_CTRL_TWO: begin
                    st_nxt.result_format_select = bus_req_in.wdata[sac_pkg::BIT_FORMAT];
                    st_nxt.channel_select = bus_req_in.wdata[sac_pkg::MUX_LSB +: 3];
                    st_nxt.clock_prescale_select = bus_req_in.wdata[sac_pkg::APS_LSB +: 4];
                end
                sac_pkg::ADDR_WIN_UPPER: st_nxt.window_upper_limit = bus_req_in.wdata;
                sac_pkg::ADDR_WIN_LOWER: st_nxt.window_lower_limit = bus_req_in.wdata;
                sac_pkg::ADDR_CLK_DIV: st_nxt.machine_clock_divider = bus_req_in.wdata[1:0];
                default: ;
            endcase
        end

        // A write of 0 to start/busy leaves it alone; only hardware clears it.
        sw_start = wr_ctrl_one && bus_req_in.wdata[sac_pkg::BIT_START_BUSY];
        if (!st_r.start_busy_bit && power_nxt &&
                (sw_start || (pin_fall && st_r.external_start_enable))) begin
            st_nxt.start_busy_bit = 1'b1;
            st_nxt.phase = sac_pkg::SAC_SAMPLE;
            st_nxt.seq_cnt = 4'h0;
            st_nxt.channel_active = st_nxt.channel_select;
            st_nxt.sample = 1'b1;
            st_nxt.restart = 1'b1;
        end

        case (st_r.phase)
            sac_pkg::SAC_IDLE: begin
                st_nxt.sample = st_nxt.sample && st_nxt.start_busy_bit;
            end
            sac_pkg::SAC_SAMPLE: begin
                if (aclk_tick) begin
                    st_nxt.seq_cnt = st_r.seq_cnt + 4'h1;
                    if (st_r.seq_cnt == sac_pkg::SEQ_SAMPLE_LAST) begin
                        st_nxt.sample = 1'b0;
                        st_nxt.phase = sac_pkg::SAC_APPROX;
                        st_nxt.approximation_register = sac_pkg::SAR_FIRST_TRIAL;
                    end
                end
            end
            sac_pkg::SAC_APPROX: begin
                if (aclk_tick) begin
                    st_nxt.seq_cnt = st_r.seq_cnt + 4'h1;
                    if (st_r.seq_cnt == sac_pkg::SEQ_FINAL) begin
                        st_nxt.result = st_r.approximation_register;
                        st_nxt.eoc_flag = 1'b1;
                        st_nxt.window_match_flag = st_r.window_outside_select
                            ^ (st_r.window_upper_limit < upper_byte)
                            ^ (st_r.window_lower_limit < upper_byte);
                        if (st_r.continuous_mode_select) begin
                            st_nxt.phase = sac_pkg::SAC_RELOAD;
                        end else begin
                            st_nxt.phase = sac_pkg::SAC_IDLE;
                            st_nxt.start_busy_bit = 1'b0;
                        end
                    end else begin
                        if (!comp_dac_below_in) begin
                            st_nxt.approximation_register[bit_idx] = 1'b0;
                        end
                        if (bit_idx != 4'h0) begin
                            st_nxt.approximation_register[bit_idx - 4'h1] = 1'b1;
                        end
                    end
                end
            end
            sac_pkg::SAC_RELOAD: begin
                if (!st_r.continuous_mode_select) begin
                    st_nxt.phase = sac_pkg::SAC_IDLE;
                    st_nxt.start_busy_bit = 1'b0;
                end else if (mclk_tick) begin
                    st_nxt.phase = sac_pkg::SAC_SAMPLE;
                    st_nxt.seq_cnt = 4'h0;
                    st_nxt.channel_active = st_r.channel_select;
                    st_nxt.sample = 1'b1;
                    st_nxt.restart = 1'b1;
                end
            end
            default: begin
                st_nxt.phase = sac_pkg::SAC_IDLE;
            end
        endcase

        // Only power removal stops a conversion once it runs.
        if (!power_nxt) begin
            st_nxt.phase = sac_pkg::SAC_IDLE;
            st_nxt.start_busy_bit = 1'b0;
            st_nxt.sample = 1'b0;
            st_nxt.restart = 1'b0;
        end

        st_nxt.irq = st_nxt.eoc_flag
            && (!st_nxt.window_qualify_enable || st_nxt.window_match_flag);

        st_nxt.rdata = sac_pkg::RST_BYTE;
        if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                sac_pkg::ADDR_CTRL_ONE: st_nxt.rdata = ctrl_one_rd;
                sac_pkg::ADDR_CTRL_TWO: st_nxt.rdata = ctrl_two_rd;
                sac_pkg::ADDR_RES_MSB: st_nxt.rdata = msb_rd;
                sac_pkg::ADDR_RES_LSB: st_nxt.rdata = st_r.result[7:0];
                sac_pkg::ADDR_WIN_UPPER: st_nxt.rdata = st_r.window_upper_limit;
                sac_pkg::ADDR_WIN_LOWER: st_nxt.rdata = st_r.window_lower_limit;
                sac_pkg::ADDR_CLK_DIV: st_nxt.rdata = {6'h00, st_r.machine_clock_divider};
                default: st_nxt.rdata = sac_pkg::RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
            st_r.pin_sync1 <= 1'b1;
            st_r.pin_sync2 <= 1'b1;
            st_r.pin_prev <= 1'b1;
            st_r.result <= sac_pkg::RST_RESULT;
            st_r.machine_clock_divider <= sac_pkg::RST_DIV;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata_out = st_r.rdata;
    assign dac_code_out = st_r.approximation_register;
    assign channel_out = st_r.channel_active;
    assign sample_out = st_r.sample;
    assign power_on_out = st_r.converter_power_on;
    assign converter_irq_out = st_r.irq;

endmodule // sac_core

/* File: src/sac_pkg.sv */
package sac_pkg;

    // Register addresses on the plain register port.
    localparam logic [7:0] ADDR_CTRL_ONE = 8'hB2;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'hB3;
    localparam logic [7:0] ADDR_RES_MSB = 8'hB4;
    localparam logic [7:0] ADDR_RES_LSB = 8'hB5;
    localparam logic [7:0] ADDR_WIN_UPPER = 8'hB6;
    localparam logic [7:0] ADDR_WIN_LOWER = 8'hB7;
    localparam logic [7:0] ADDR_CLK_DIV = 8'hB8;

    // Field positions in the first control register.
    localparam int BIT_START_BUSY = 7;
    localparam int BIT_EOC = 6;
    localparam int BIT_CONT = 5;
    localparam int BIT_EXT_START = 4;
    localparam int BIT_QUALIFY = 3;
    localparam int BIT_MATCH = 2;
    localparam int BIT_POWER = 1;
    localparam int BIT_OUTSIDE = 0;

    // Field positions in the second control register.
    localparam int BIT_FORMAT = 7;
    localparam int MUX_LSB = 4;
    localparam int APS_LSB = 0;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [9:0] RST_RESULT = 10'h000;
    localparam logic [1:0] RST_DIV = 2'h0;

    // Machine clock divider codes and the last count of each division.
    localparam logic [1:0] DIV_SEL_4 = 2'h0;
    localparam logic [1:0] DIV_SEL_64 = 2'h1;
    localparam logic [9:0] MDIV_LAST_4 = 10'h003;
    localparam logic [9:0] MDIV_LAST_64 = 10'h03F;
    localparam logic [9:0] MDIV_LAST_1024 = 10'h3FF;

    // Conversion sequence, counted in conversion clocks from zero.
    localparam logic [3:0] SEQ_SAMPLE_LAST = 4'h4;
    localparam logic [3:0] SEQ_DECIDE_LAST = 4'hE;
    localparam logic [3:0] SEQ_FINAL = 4'hF;
    localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_SAMPLE = 2'b01,
        SAC_APPROX = 2'b10,
        SAC_RELOAD = 2'b11
    } sac_phase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sac_bus_req_t;

    typedef struct packed {
        logic [1:0] div_sel;
        logic [3:0] prescale;
        logic restart;
    } sac_clk_cfg_t;

endpackage

/* File: verif/sac_analog_model.sv */
`timescale 1ns/1ps

module sac_analog_model (
    input wire logic [9:0] dac_code_in,
    input wire logic [2:0] channel_in,
    input wire logic [9:0] level_in [8],
    output logic comp_dac_below_out
);
    // A trial stays below the held input up to the channel level, so the result equals it.
    assign comp_dac_below_out = dac_code_in <= level_in[channel_in];
endmodule // sac_analog_model

/* File: verif/sac_core_monitor.sv */
`timescale 1ns/1ps

module sac_core_monitor (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire sac_pkg::sac_bus_req_t bus_req_in,
    input wire logic [7:0] bus_rdata_out,
    input wire logic ext_start_n_in,
    input wire logic comp_dac_below_in,
    input wire logic [9:0] dac_code_out,
    input wire logic [2:0] channel_out,
    input wire logic sample_out,
    input wire logic power_on_out,
    input wire logic converter_irq_out
);
    logic [7:0] ctrl_two_r;
    logic pwr_wr_r;
    logic pwr_bit_r;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    // Shadow of the second control register and of the last power write.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_two_r <= 8'h00;
            pwr_wr_r <= 1'b0;
            pwr_bit_r <= 1'b0;
        end else begin
            if (bus_req_in.wr && bus_req_in.addr == sac_pkg::ADDR_CTRL_TWO) begin
                ctrl_two_r <= bus_req_in.wdata;
            end
            pwr_wr_r <= bus_req_in.wr && bus_req_in.addr == sac_pkg::ADDR_CTRL_ONE;
            pwr_bit_r <= bus_req_in.wdata[sac_pkg::BIT_POWER];
        end
    end

    sequence s_sample_start;
        $rose(sample_out);
    endsequence

    sequence s_sample_end;
        $fell(sample_out) && power_on_out;
    endsequence

    a_sample_hold: assert property (s_sample_start |-> (sample_out || !power_on_out)[*8])
        else $error("sample window ended too early");
    a_sample_power: assert property (s_sample_start |-> power_on_out)
        else $error("conversion started without power");
    a_first_trial: assert property (s_sample_end |-> ##[0:4] dac_code_out == 10'h200)
        else $error("first trial code is not the top bit");
    a_approx_gap: assert property (s_sample_end |=> !sample_out[*8])
        else $error("sampling resumed during approximation");
    a_chan_hold: assert property (sample_out && $past(sample_out) |-> $stable(channel_out))
        else $error("channel changed while sampling");
    a_power_gate: assert property (!power_on_out |-> !sample_out)
        else $error("sampling while powered down");
    a_power_write: assert property (pwr_wr_r |-> power_on_out == pwr_bit_r)
        else $error("power output does not follow the written bit");
    a_ctrl_two_read: assert property (
        bus_req_in.rd && bus_req_in.addr == sac_pkg::ADDR_CTRL_TWO |=>
        bus_rdata_out == ctrl_two_r)
        else $error("second control register read back wrong");
endmodule // sac_core_monitor

/* File: verif/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    localparam logic [7:0] C1 = sac_pkg::ADDR_CTRL_ONE;
    localparam logic [7:0] C2 = sac_pkg::ADDR_CTRL_TWO;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    sac_pkg::sac_bus_req_t req = '0;
    logic ext_n = 1'b1;
    logic [7:0] rdata;
    logic [9:0] dac;
    logic [2:0] chan;
    logic comp, samp, pwr, irq;
    logic [9:0] lvl [8] = '{10'h000, 10'h3FF, 10'h2AA, 10'h155, 10'h200, 10'h1FF, 10'h0F3, 10'h301};
    logic [7:0] rv;
    int bad_count = 0;
    int comparisons = 0;
    int pre [4] = '{0, 15, 3, 0};
    int dv [4] = '{4, 4, 64, 1024};

    sac_core dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .bus_req_in(req),
        .bus_rdata_out(rdata), .ext_start_n_in(ext_n), .comp_dac_below_in(comp),
        .dac_code_out(dac), .channel_out(chan), .sample_out(samp), .power_on_out(pwr),
        .converter_irq_out(irq));
    sac_analog_model model (.dac_code_in(dac), .channel_in(chan), .level_in(lvl),
        .comp_dac_below_out(comp));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk_in);
        req <= '0;
        @(posedge core_clk_in);
    endtask

    task automatic rd(input logic [7:0] a);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk_in);
        req <= '0;
        #1 rv = rdata;
        @(posedge core_clk_in);
    endtask

    task automatic wait_idle();
        int n = 0;
        do begin
            rd(C1);
            n++;
        end while (rv[7] !== 1'b0 && n < 3000);
        check(16'(n < 3000), 16'h0001);
    endtask

    initial begin
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    initial begin
        repeat (60000) @(posedge core_clk_in);
        bad_count++;
        report_and_stop();
    end

    initial begin
        logic [7:0] up, lo, u;
        logic o, q, f, m;
        int cnt;
        int p;
        repeat (8) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        // Every register reads zero after reset, including the unmapped address above them.
        for (int a = 8'hB2; a <= 8'hB9; a++) begin
            rd(8'(a));
            check(rv, 16'h0000);
        end
        check(pwr, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            up = 8'(i * 37);
            lo = 8'(192 - i * 24);
            {f, q, o} = 3'(i);
            u = lvl[i][9:2];
            m = o ^ (up < u) ^ (lo < u);
            wr(8'hB6, up);
            wr(8'hB7, lo);
            wr(C2, {f, 3'(i), 4'h0});
            wr(C1, {4'h8, q, 2'b01, o});
            wait_idle();
            rd(C1);
            check(rv, {4'h4, q, m, 1'b1, o});
            check(irq, 16'(!q || m));
            rd(8'hB4);
            check(rv, f ? {6'h00, lvl[i][9:8]} : u);
            rd(8'hB5);
            check(rv, lvl[i][7:0]);
        end
        wr(C2, 8'h05);
        wr(C1, 8'h82);
        wr(C1, 8'h02);
        rd(C1);
        check(rv[7], 16'h0001);
        // The match flag of the last loop conversion is set and only a conversion updates it.
        wr(C1, 8'h00);
        rd(C1);
        check({rv, samp}, 16'h0008);
        repeat (500) @(posedge core_clk_in);
        rd(C1);
        check(rv, 16'h0004);
        wr(C2, 8'h00);
        wr(C1, 8'hA2);
        cnt = 0;
        for (int k = 0; k < 150; k++) begin
            rd(C1);
            cnt += int'(!rv[7]);
        end
        check(16'(cnt), 16'h0000);
        check(rv[6], 16'h0001);
        wr(C1, 8'h82);
        wait_idle();
        repeat (100) @(posedge core_clk_in);
        rd(C1);
        check(rv[7], 16'h0000);
        wr(C1, 8'h12);
        ext_n <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        rd(C1);
        check(rv[7], 16'h0001);
        ext_n <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        ext_n <= 1'b0;
        wait_idle();
        repeat (8) @(posedge core_clk_in);
        rd(C1);
        check(rv[7], 16'h0000);
        ext_n <= 1'b1;
        wr(C1, 8'h02);
        ext_n <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        rd(C1);
        check(rv[7], 16'h0000);
        for (int j = 0; j < 4; j++) begin
            wr(8'hB8, 8'(j < 2 ? 0 : j - 1));
            wr(C2, 8'(pre[j]));
            wr(C1, 8'h02);
            wr(C1, 8'h82);
            cnt = 0;
            while (irq !== 1'b1 && cnt < 20000) begin
                @(posedge core_clk_in);
                #1 cnt++;
            end
            p = (pre[j] + 1) * dv[j];
            check(16'(cnt >= 15 * p && cnt <= 16 * p + 4), 16'h0001);
        end
        report_and_stop();
    end
endmodule // tb_top

bind sac_core sac_core_monitor mon (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out), .ext_start_n_in(ext_start_n_in),
    .comp_dac_below_in(comp_dac_below_in), .dac_code_out(dac_code_out),
    .channel_out(channel_out), .sample_out(sample_out), .power_on_out(power_on_out),
    .converter_irq_out(converter_irq_out));
